// ---- core/nco_consts.svh ----
// Purpose: constants of the phase accumulator and sine lookup core
// Assumes: 250 MHz core clock, plain register port with 32-bit data
// Notes: offsets are byte addresses on the register port
//
// Notes on behaviour
// - Phase held in 28-bit accumulator.
// - Accumulator wraps modulo two to the 28.
// - Step from word a or b, pin or bit.
// - Switching step never reloads the accumulator.
// - Two 12-bit phase offset registers.
// - Offset added to accumulator top bits.
// - Offset lsb is one 4096th cycle.
// - Top 12 phase bits address sine table.
// - Mode set with output-bit-enable clear bypasses the table.
// - 10-bit sample to converter every cycle.
// - Comparator to sign pin when both bits set.
// - Offset chosen by pin or bit.
// - Core reset clears pipeline, keeps registers.
// - Output frequency is binary fraction of clock.
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH

`define OFS_FREQ_WORD_A 8'h00
`define OFS_FREQ_WORD_B 8'h04
`define OFS_PHASE_OFFSET_A 8'h08
`define OFS_PHASE_OFFSET_B 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_STATUS 8'h14

`define CTL_FREQ_SEL_BIT 0
`define CTL_PHASE_SEL_BIT 1
`define CTL_PIN_SELECT 2
`define CTL_WAVE_MODE 3
`define CTL_OUTPUT_BIT_ENABLE 4
`define CTL_SIGN_PIN_SOURCE 5

`define RST_FREQ_WORD 28'h0000000
`define RST_PHASE_OFFSET 12'h000
`define RST_CONTROL 6'h00

`define SAMPLE_MID 10'h200
`define SINE_PEAK 511.0

`endif

// ---- core/nco_pkg.sv ----
// Purpose: shared types of the phase accumulator and sine lookup core
// Assumes: constants live in nco_consts.svh
// Notes: widths follow the accumulator, offset and converter sizes
package nco_pkg;
    typedef logic [27:0] phase_acc_t;
    typedef logic [11:0] phase_off_t;
    typedef logic [9:0] sample_t;
    typedef logic [5:0] control_t;
endpackage : nco_pkg

// ---- core/pin_sync.sv ----
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : pin_sync

// ---- core/sine_lookup.sv ----
// Purpose: 12-bit phase to 10-bit offset-binary sine amplitude
// Assumes: table built at elaboration from quarter-wave symmetry
// Notes: one registered stage; clear forces midscale
`timescale 1ns/1ns
`include "nco_consts.svh"
module sine_lookup (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clr,
    input wire nco_pkg::phase_off_t i_phase,
    output nco_pkg::sample_t o_sample
);
    logic [8:0] quarter [0:1023];
    logic [9:0] idx;
    logic [8:0] mag;
    nco_pkg::sample_t sample_d;
    nco_pkg::sample_t sample_q;

    // Half-step offset keeps the quadrant mirror exact
    for (genvar gi = 0; gi < 1024; gi++) begin : g_rom
        localparam real ANG = 2.0 * 3.14159265358979 * (real'(gi) + 0.5) / 4096.0;
        localparam int VAL = int'($floor(`SINE_PEAK * $sin(ANG) + 0.5));
        assign quarter[gi] = 9'(VAL);
    end

    always_comb begin
        idx = i_phase[10] ? ~i_phase[9:0] : i_phase[9:0];
        mag = quarter[idx];
        if (i_clr) begin
            sample_d = `SAMPLE_MID;
        end else if (i_phase[11]) begin
            sample_d = `SAMPLE_MID - {1'b0, mag};
        end else begin
            sample_d = `SAMPLE_MID + {1'b0, mag};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sample_q <= `SAMPLE_MID;
        end else begin
            sample_q <= sample_d;
        end
    end

    assign o_sample = sample_q;
endmodule : sine_lookup

// ---- core/nco_core.sv ----
// Purpose: phase accumulator, phase offset, sine or ramp samples, sign pin
// Assumes: pins and comparator result are asynchronous; register port synchronous
// Notes: core reset pin clears only the accumulator and sample pipeline
`timescale 1ns/1ns
`include "nco_consts.svh"
module nco_core (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_freq_sel_pin,
    input wire logic i_phase_sel_pin,
    input wire logic i_nco_reset_pin,
    input wire logic i_cmp_in,
    output nco_pkg::sample_t o_dac_data,
    output logic o_sign_out,
    output logic o_sign_en
);
    logic [3:0] pins_s;
    logic freq_sel_pin;
    logic phase_sel_pin;
    logic clr;
    logic cmp_s;

    pin_sync #(.W(4)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_cmp_in, i_nco_reset_pin, i_phase_sel_pin, i_freq_sel_pin}),
        .o_sync(pins_s)
    );

    assign freq_sel_pin = pins_s[0];
    assign phase_sel_pin = pins_s[1];
    assign clr = pins_s[2];
    assign cmp_s = pins_s[3];

    // Register file
    nco_pkg::phase_acc_t freq_word_a_q, freq_word_a_d;
    nco_pkg::phase_acc_t freq_word_b_q, freq_word_b_d;
    nco_pkg::phase_off_t phase_offset_a_q, phase_offset_a_d;
    nco_pkg::phase_off_t phase_offset_b_q, phase_offset_b_d;
    nco_pkg::control_t control_q, control_d;
    logic [31:0] rdata_q, rdata_d;
    nco_pkg::phase_acc_t acc_q;

    always_comb begin
        freq_word_a_d = freq_word_a_q;
        freq_word_b_d = freq_word_b_q;
        phase_offset_a_d = phase_offset_a_q;
        phase_offset_b_d = phase_offset_b_q;
        control_d = control_q;
        rdata_d = 32'h0000_0000;
        if (i_wr) begin
            unique case (i_addr)
                `OFS_FREQ_WORD_A: freq_word_a_d = i_wdata[27:0];
                `OFS_FREQ_WORD_B: freq_word_b_d = i_wdata[27:0];
                `OFS_PHASE_OFFSET_A: phase_offset_a_d = i_wdata[11:0];
                `OFS_PHASE_OFFSET_B: phase_offset_b_d = i_wdata[11:0];
                `OFS_CONTROL: control_d = i_wdata[5:0];
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                `OFS_FREQ_WORD_A: rdata_d = {4'h0, freq_word_a_q};
                `OFS_FREQ_WORD_B: rdata_d = {4'h0, freq_word_b_q};
                `OFS_PHASE_OFFSET_A: rdata_d = {20'h00000, phase_offset_a_q};
                `OFS_PHASE_OFFSET_B: rdata_d = {20'h00000, phase_offset_b_q};
                `OFS_CONTROL: rdata_d = {26'h0000000, control_q};
                `OFS_STATUS: rdata_d = {4'h0, acc_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Registers are untouched by the core reset pin
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            freq_word_a_q <= `RST_FREQ_WORD;
            freq_word_b_q <= `RST_FREQ_WORD;
            phase_offset_a_q <= `RST_PHASE_OFFSET;
            phase_offset_b_q <= `RST_PHASE_OFFSET;
            control_q <= `RST_CONTROL;
            rdata_q <= 32'h0000_0000;
        end else begin
            freq_word_a_q <= freq_word_a_d;
            freq_word_b_q <= freq_word_b_d;
            phase_offset_a_q <= phase_offset_a_d;
            phase_offset_b_q <= phase_offset_b_d;
            control_q <= control_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // Selection
    logic pin_select;
    logic step_sel;
    logic offs_sel;
    logic bypass;
    logic bit_enable;
    logic sign_source;
    nco_pkg::phase_acc_t step;
    nco_pkg::phase_off_t offset;

    always_comb begin
        pin_select = control_q[`CTL_PIN_SELECT];
        step_sel = pin_select ? freq_sel_pin : control_q[`CTL_FREQ_SEL_BIT];
        offs_sel = pin_select ? phase_sel_pin : control_q[`CTL_PHASE_SEL_BIT];
        step = step_sel ? freq_word_b_q : freq_word_a_q;
        offset = offs_sel ? phase_offset_b_q : phase_offset_a_q;
        bit_enable = control_q[`CTL_OUTPUT_BIT_ENABLE];
        sign_source = control_q[`CTL_SIGN_PIN_SOURCE];
        bypass = control_q[`CTL_WAVE_MODE] && !bit_enable;
    end

    // Accumulator and phase pipeline
    nco_pkg::phase_acc_t acc_d;
    nco_pkg::phase_off_t phase12_q, phase12_d;
    nco_pkg::sample_t tri_q, tri_d;
    nco_pkg::sample_t sine;
    nco_pkg::sample_t dac_q, dac_d;
    logic sign_q, sign_d;
    logic sign_en_q, sign_en_d;

    always_comb begin
        // Carry out of the top bit is dropped, so phase wraps
        acc_d = clr ? 28'h0000000 : 28'(acc_q + step);
        phase12_d = clr ? 12'h000 : 12'(acc_q[27:16] + offset);
        if (clr) begin
            tri_d = `SAMPLE_MID;
        end else if (phase12_q[11]) begin
            tri_d = ~phase12_q[10:1];
        end else begin
            tri_d = phase12_q[10:1];
        end
        dac_d = clr ? `SAMPLE_MID : (bypass ? tri_q : sine);
        sign_en_d = bit_enable;
        if (!bit_enable) begin
            sign_d = 1'b0;
        end else if (sign_source) begin
            sign_d = cmp_s;
        end else begin
            sign_d = dac_q[9];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_q <= 28'h0000000;
            phase12_q <= 12'h000;
            tri_q <= `SAMPLE_MID;
            dac_q <= `SAMPLE_MID;
            sign_q <= 1'b0;
            sign_en_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            phase12_q <= phase12_d;
            tri_q <= tri_d;
            dac_q <= dac_d;
            sign_q <= sign_d;
            sign_en_q <= sign_en_d;
        end
    end

    sine_lookup u_lut (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clr(clr),
        .i_phase(phase12_q),
        .o_sample(sine)
    );

    assign o_dac_data = dac_q;
    assign o_sign_out = sign_q;
    assign o_sign_en = sign_en_q;

    // Checks
    sequence clr_hold;
        clr [*3];
    endsequence

    sequence run2;
        !clr [*2];
    endsequence

    chk_acc_step: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        run2 |-> acc_q == 28'($past(acc_q) + $past(step))
    ) else $error("accumulator did not advance by the step");

    chk_acc_wrap: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && (29'(acc_q) + 29'(step) > 29'h0FFFFFFF)) |=> acc_q < $past(acc_q)
    ) else $error("accumulator did not wrap");

    chk_switch_cont: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && $changed(step_sel)) ##1 !clr |-> acc_q == 28'($past(acc_q) + $past(step))
    ) else $error("phase jumped on step switch");

    chk_pin_step: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && pin_select && freq_sel_pin) ##1 !clr
            |-> acc_q == 28'($past(acc_q) + $past(freq_word_b_q))
    ) else $error("pin did not pick second frequency word");

    chk_phase_add: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !clr ##1 !clr |-> phase12_q == 12'($past(acc_q[27:16]) + $past(offset))
    ) else $error("offset not added to top phase bits");

    chk_reset_mid: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        clr_hold |=> o_dac_data == `SAMPLE_MID && acc_q == 28'h0000000
    ) else $error("core reset did not give midscale");

    chk_regs_kept: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (clr && !i_wr) |=> $stable(freq_word_a_q) && $stable(control_q)
    ) else $error("core reset disturbed a register");

    chk_tri_bypass: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (bypass && !clr) ##1 (bypass && !clr) |=> o_dac_data == $past(tri_q)
    ) else $error("bypass did not pass the ramp");

    chk_dac_sine: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!bypass && !clr) |=> o_dac_data == $past(sine)
    ) else $error("sample not taken from sine table");

    chk_sign_cmp: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (bit_enable && sign_source) |=> o_sign_out == $past(cmp_s) && o_sign_en
    ) else $error("comparator not routed to sign pin");

    chk_sign_off: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !bit_enable |=> !o_sign_en && !o_sign_out
    ) else $error("sign pin driven while disabled");

    sequence run3;
        !clr [*3];
    endsequence

    chk_freq_bit: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && !pin_select && control_q[`CTL_FREQ_SEL_BIT])
            |=> acc_q == 28'($past(acc_q) + $past(freq_word_b_q))
    ) else $error("control bit did not pick second frequency word");

    chk_freq_first: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && !step_sel) |=> acc_q == 28'($past(acc_q) + $past(freq_word_a_q))
    ) else $error("first frequency word not used");

    chk_offs_pin: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && pin_select && phase_sel_pin)
            |=> phase12_q == 12'($past(acc_q[27:16]) + $past(phase_offset_b_q))
    ) else $error("pin did not pick second phase offset");

    chk_offs_bit: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && !pin_select && !control_q[`CTL_PHASE_SEL_BIT])
            |=> phase12_q == 12'($past(acc_q[27:16]) + $past(phase_offset_a_q))
    ) else $error("control bit did not pick first phase offset");

    chk_sine_upper: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && !phase12_q[11]) |=> sine >= `SAMPLE_MID
    ) else $error("first half cycle below midscale");

    chk_sine_lower: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && phase12_q[11]) |=> sine <= `SAMPLE_MID
    ) else $error("second half cycle above midscale");

    chk_tri_rise: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && !phase12_q[11]) |=> tri_q == $past(phase12_q[10:1])
    ) else $error("ramp not rising in first half");

    chk_tri_fall: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!clr && phase12_q[11]) |=> tri_q == ~$past(phase12_q[10:1])
    ) else $error("ramp not falling in second half");

    chk_clr_pipe: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        clr |=> acc_q == 28'h0000000 && phase12_q == 12'h000
    ) else $error("core reset did not clear the phase pipeline");

    chk_sign_msb: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (bit_enable && !sign_source) |=> o_sign_out == $past(dac_q[9]) && o_sign_en
    ) else $error("sample msb not routed to sign pin");

    chk_acc_two: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        run3 |-> acc_q == 28'($past(acc_q, 2) + $past(step, 2) + $past(step))
    ) else $error("accumulator did not step once per clock");
endmodule : nco_core

// ---- testbench/cmp_model.sv ----
// Purpose: comparator partner that squares up converter samples
// Assumes: bench threshold stands in for the averaged reference
// Notes: output registered one cycle behind the sample
`timescale 1ns/1ns
module cmp_model (
    input wire logic i_clk,
    input wire nco_pkg::sample_t i_sample,
    input wire nco_pkg::sample_t i_thresh,
    output logic o_cmp
);
    always_ff @(posedge i_clk) begin
        o_cmp <= (i_sample > i_thresh);
    end
endmodule : cmp_model

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the phase accumulator core
// Assumes: register map and control bits from nco_consts.svh
// Notes: accumulator frozen with zero steps for waveform checks
`timescale 1ns/1ns
`include "nco_consts.svh"
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic freq_pin = 1'b0;
    logic phase_pin = 1'b0;
    logic nreset_pin = 1'b0;
    logic [31:0] rdata;
    nco_pkg::sample_t dac;
    nco_pkg::sample_t thresh = 10'h000;
    logic sign_out;
    logic sign_en;
    logic cmp;
    int bad_count = 0;
    int total_checks = 0;

    always #2 clk = ~clk;

    nco_core dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_freq_sel_pin(freq_pin),
        .i_phase_sel_pin(phase_pin), .i_nco_reset_pin(nreset_pin), .i_cmp_in(cmp),
        .o_dac_data(dac), .o_sign_out(sign_out), .o_sign_en(sign_en));
    cmp_model cmp_u (.i_clk(clk), .i_sample(dac), .i_thresh(thresh), .o_cmp(cmp));

    task print_verdict;
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd

    task rate(input logic [27:0] st);
        logic [31:0] s0;
        logic [31:0] s1;
        logic [27:0] e;
        repeat (10) @(posedge clk);
        rd(`OFS_STATUS, s0);
        repeat (5) @(posedge clk);
        rd(`OFS_STATUS, s1);
        e = st * 28'd8;
        chk("acc_step", {4'h0, e}, (s1 - s0) & 32'h0FFFFFFF);
    endtask : rate

    function automatic logic [9:0] ramp(input logic [11:0] p);
        return p[11] ? ~p[10:1] : p[10:1];
    endfunction : ramp

    task wave(input logic [5:0] c, input logic [9:0] e);
        wr(`OFS_CONTROL, {26'h0, c});
        repeat (10) @(posedge clk);
        chk("dac", {22'h0, e}, {22'h0, dac});
    endtask : wave

    task t_regs;
        logic [31:0] d;
        rd(`OFS_CONTROL, d);
        chk("ctrl_rst", 32'h0, d);
        wr(`OFS_FREQ_WORD_A, 32'hFABCDEF1);
        rd(`OFS_FREQ_WORD_A, d);
        chk("freq_a", 32'h0ABCDEF1, d);
        wr(`OFS_PHASE_OFFSET_A, 32'hFFFFFFFF);
        rd(`OFS_PHASE_OFFSET_A, d);
        chk("off_a", 32'h00000FFF, d);
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, d);
        chk("unmapped", 32'h0, d);
    endtask : t_regs

    task t_step;
        wr(`OFS_PHASE_OFFSET_A, 32'h0);
        wr(`OFS_FREQ_WORD_A, 32'h0FFFFFFF);
        wr(`OFS_FREQ_WORD_B, 32'h00123457);
        wr(`OFS_CONTROL, 32'h0);
        rate(28'hFFFFFFF);
        wr(`OFS_CONTROL, 32'h1);
        rate(28'h0123457);
        freq_pin <= 1'b1;
        wr(`OFS_CONTROL, 32'h4);
        rate(28'h0123457);
        freq_pin <= 1'b0;
        rate(28'hFFFFFFF);
    endtask : t_step

    task t_cont;
        logic [31:0] s0;
        logic [31:0] s1;
        wr(`OFS_FREQ_WORD_A, 32'h0);
        wr(`OFS_FREQ_WORD_B, 32'h0);
        repeat (10) @(posedge clk);
        rd(`OFS_STATUS, s0);
        wr(`OFS_CONTROL, 32'h1);
        repeat (10) @(posedge clk);
        rd(`OFS_STATUS, s1);
        chk("acc_keep", s0, s1);
    endtask : t_cont

    task t_wave;
        logic [31:0] d;
        logic [11:0] offs [6];
        offs = '{12'h000, 12'h001, 12'h002, 12'h7FF, 12'h800, 12'hC35};
        wr(`OFS_FREQ_WORD_B, 32'h01234567);
        wr(`OFS_CONTROL, 32'h0);
        nreset_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("dac_mid", 32'h200, {22'h0, dac});
        rd(`OFS_FREQ_WORD_B, d);
        chk("freq_b_kept", 32'h01234567, d);
        nreset_pin <= 1'b0;
        foreach (offs[i]) begin
            wr(`OFS_PHASE_OFFSET_A, {20'h0, offs[i]});
            wave(6'h08, ramp(offs[i]));
        end
        wr(`OFS_PHASE_OFFSET_B, 32'h400);
        wave(6'h0A, ramp(12'h400));
        wave(6'h0E, ramp(12'hC35));
        phase_pin <= 1'b1;
        wave(6'h0C, ramp(12'h400));
        phase_pin <= 1'b0;
        wave(6'h1A, 10'h3FF);
        chk("sign_msb", 32'h1, {31'h0, sign_out});
        thresh <= 10'h3FF;
        wave(6'h3A, 10'h3FF);
        chk("sign_cmp0", 32'h2, {30'h0, sign_en, sign_out});
        thresh <= 10'h000;
        repeat (6) @(posedge clk);
        chk("sign_cmp1", 32'h3, {30'h0, sign_en, sign_out});
        wave(6'h2A, ramp(12'h400));
        chk("sign_off", 32'h0, {30'h0, sign_en, sign_out});
        wr(`OFS_PHASE_OFFSET_A, 32'hC00);
        wave(6'h18, 10'h001);
    endtask : t_wave

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_step();
        t_cont();
        t_wave();
        print_verdict();
    end

    initial begin
        #80000;
        bad_count++;
        print_verdict();
    end
endmodule : testbench
